/* design/mtaalu_core.sv */
// Overview of operation
// - Opcode 0010 000f ffff copies the operand into the accumulator.
// - Copy sets zero flag when value is 00h, else clears it.
// - No instruction here writes back to the source file register.
// - Opcode 0010 010f ffff loads the operand inverted (XOR FFh).
// - Complement load sets zero flag when result is 00h, else clears.
// - Opcode 0000 100f ffff loads operand minus accumulator, low 8 bits.
// - Subtraction clears carry on borrow out of bit 7, else sets it.
// - Subtraction clears digit carry on borrow from bit 3, else sets.
// - Subtraction sets zero flag on 00h result, else clears.
// - Fuse bit at 0 also subtracts inverted carry as borrow-in.
// - Opcode 0000 110f ffff loads operand minus one.
// - Decrement sets zero flag only when operand was 01h.
// - Opcode 0010 100f ffff loads operand plus one.
// - Increment sets zero flag only when operand was FFh.
module mtaalu_core
   import mtaalu_pkg::*;
(
   input  wire logic                   clock_i,               // Core clock
   input  wire logic                   reset_i,               // Sync reset
   input  wire logic                   exec_i,                // Execute opcode this cycle
   input  wire logic [11:0]            opcode_i,              // Instruction word
   input  wire logic [7:0]             file_register_operand_i, // Operand read data
   input  wire logic                   carry_in_fuse_bit_i,   // Fuse, 0 enables borrow-in
   output logic [4:0]                  operand_addr_o,        // Operand address
   output logic                        operand_write_o,       // Write-back strobe, never set
   output logic [7:0]                  acc_o,                 // Working accumulator
   output logic                        zero_flag_o,           // Zero flag
   output logic                        carry_flag_o,          // Carry flag
   output logic                        digit_carry_flag_o,    // Digit-carry flag
   output logic                        done_o                 // Load completed
);
   import mtaalu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0] acc;
      logic       zf;
      logic       carry;
      logic       dcf;
      logic       wr;
      logic       done;
   } mtaalu_state_type;

   mtaalu_state_type state_ff;
   mtaalu_state_type nxt_state;
   mtaalu_op_type    op;
   logic [4:0]       addr;

   // Opcode decoder
   mtaalu_decode u_decode (
      .opcode_i (opcode_i),
      .op_o     (op),
      .addr_o   (addr)
   );

   assign operand_addr_o = addr;

   ////////////////////////////////////////////////////////////////////////////
   // Datapath

   logic       borrow_in;
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic [7:0] result;

   // Borrow-in only when the fuse is programmed to 0
   // Carry reads as no borrow, so a clear carry takes one more away
   // Ninth bit of the difference is the borrow out of bit 7
   // Fifth bit of the low-nibble difference is the borrow out of bit 3
   always_comb begin
      borrow_in = (~carry_in_fuse_bit_i) & (~state_ff.carry);
      diff      = {1'b0, file_register_operand_i} - {1'b0, state_ff.acc}
                  - {8'h00, borrow_in};
      low_diff  = {1'b0, file_register_operand_i[3:0]} - {1'b0, state_ff.acc[3:0]}
                  - {4'h0, borrow_in};
   end

   // Next state
   always_comb begin
      nxt_state      = state_ff;
      nxt_state.wr   = 1'b0;
      nxt_state.done = 1'b0;
      result         = state_ff.acc;
      if (exec_i && op != MTA_NONE) begin
         case (op)
            MTA_COPY: result = file_register_operand_i;
            MTA_COMP: result = file_register_operand_i ^ ALL_ONES;
            MTA_SUB: begin
               result        = diff[7:0];
               nxt_state.carry = ~diff[8];
               nxt_state.dcf = ~low_diff[4];
            end
            MTA_DEC: result = file_register_operand_i - ONE;
            MTA_INC: result = file_register_operand_i + ONE;
            default: result = state_ff.acc;
         endcase
         nxt_state.acc  = result;
         nxt_state.zf   = (result == ZERO);
         nxt_state.done = 1'b1;
      end
      if (reset_i) begin
         nxt_state.acc  = ACC_RST;
         nxt_state.zf   = FLAG_RST;
         nxt_state.carry = FLAG_RST;
         nxt_state.dcf  = FLAG_RST;
         nxt_state.wr   = 1'b0;
         nxt_state.done = 1'b0;
      end
   end

   // Register
   always_ff @(posedge clock_i) begin
      state_ff <= nxt_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign acc_o              = state_ff.acc;
   assign zero_flag_o        = state_ff.zf;
   assign carry_flag_o       = state_ff.carry;
   assign digit_carry_flag_o = state_ff.dcf;
   assign operand_write_o    = state_ff.wr;
   assign done_o             = state_ff.done;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Instruction strobe for one load kind
   sequence s_exec(logic [6:0] sel);
      exec_i && opcode_i[11:5] == sel;
   endsequence

   // Subtraction with the fuse at 1, no borrow-in at all
   sequence s_sub_plain;
      exec_i && opcode_i[11:5] == SEL_SUB && carry_in_fuse_bit_i;
   endsequence

   // Fuse at 0 and carry clear, one extra borrow
   sequence s_sub_borrow;
      exec_i && opcode_i[11:5] == SEL_SUB && !carry_in_fuse_bit_i && !carry_flag_o;
   endsequence

   // Fuse at 0 but carry set, borrow-in is zero
   sequence s_sub_noborrow;
      exec_i && opcode_i[11:5] == SEL_SUB && !carry_in_fuse_bit_i && carry_flag_o;
   endsequence

   // Copy and complement loads, and no write-back strobe
   chk_copy_value: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_COPY) |=> acc_o == $past(file_register_operand_i))
      else $error("copy load wrong");

   chk_copy_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_COPY) |=> zero_flag_o == ($past(file_register_operand_i) == 8'h00))
      else $error("copy zero flag wrong");

   chk_no_write: assert property (@(posedge clock_i) disable iff (reset_i)
      exec_i |=> !operand_write_o)
      else $error("operand written back");

   chk_write_low: assert property (@(posedge clock_i) disable iff (reset_i)
      !operand_write_o)
      else $error("write-back strobe raised");

   chk_comp_value: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_COMP) |=> acc_o == ~$past(file_register_operand_i))
      else $error("complement load wrong");

   chk_comp_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_COMP) |=> zero_flag_o == ($past(file_register_operand_i) == 8'hff))
      else $error("complement zero flag wrong");

   // Subtraction, plain and with borrow-in
   chk_sub_value: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_plain |=>
      acc_o == 8'($past(file_register_operand_i) - $past(acc_o)))
      else $error("subtract result wrong");

   chk_sub_carry: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_plain |=>
      carry_flag_o == ($past(acc_o) <= $past(file_register_operand_i)))
      else $error("subtract carry wrong");

   chk_sub_dcarry: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_plain |=>
      digit_carry_flag_o == ($past(acc_o[3:0]) <= $past(file_register_operand_i[3:0])))
      else $error("subtract digit carry wrong");

   chk_sub_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_SUB) |=> zero_flag_o == (acc_o == 8'h00))
      else $error("subtract zero flag wrong");

   chk_sub_borrow: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_borrow |=>
      acc_o == 8'($past(file_register_operand_i) - $past(acc_o) - 8'h01))
      else $error("borrow-in ignored");

   chk_sub_b_carry: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_borrow |=>
      carry_flag_o == ($past(acc_o) < $past(file_register_operand_i)))
      else $error("borrow-in carry wrong");

   chk_sub_b_dcarry: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_borrow |=>
      digit_carry_flag_o == ($past(acc_o[3:0]) < $past(file_register_operand_i[3:0])))
      else $error("borrow-in digit carry wrong");

   chk_sub_nb_value: assert property (@(posedge clock_i) disable iff (reset_i)
      s_sub_noborrow |=>
      acc_o == 8'($past(file_register_operand_i) - $past(acc_o)))
      else $error("borrow-in applied with carry set");

   chk_sub_done: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_SUB) |=>
      done_o)
      else $error("subtract not completed");

   // Decrement and increment loads
   chk_dec_value: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_DEC) |=> acc_o == 8'($past(file_register_operand_i) - 8'h01))
      else $error("decrement load wrong");

   chk_dec_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_DEC) |=> zero_flag_o == ($past(file_register_operand_i) == 8'h01))
      else $error("decrement zero flag wrong");

   chk_inc_value: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_INC) |=> acc_o == 8'($past(file_register_operand_i) + 8'h01))
      else $error("increment load wrong");

   chk_inc_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_INC) |=> zero_flag_o == ($past(file_register_operand_i) == 8'hff))
      else $error("increment zero flag wrong");

   // Untouched flags and single-cycle completion
   chk_flags_kept: assert property (@(posedge clock_i) disable iff (reset_i)
      exec_i && op != MTA_SUB && op != MTA_NONE |=> done_o && $stable(carry_flag_o)
      && $stable(digit_carry_flag_o))
      else $error("flags disturbed");

   chk_copy_flags: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_COPY) |=>
      $stable(carry_flag_o) && $stable(digit_carry_flag_o) && done_o)
      else $error("copy disturbed carry flags");

   chk_comp_flags: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_COMP) |=>
      $stable(carry_flag_o) && $stable(digit_carry_flag_o) && done_o)
      else $error("complement disturbed carry flags");

   chk_dec_flags: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_DEC) |=>
      $stable(carry_flag_o) && $stable(digit_carry_flag_o) && done_o)
      else $error("decrement disturbed carry flags");

   chk_inc_flags: assert property (@(posedge clock_i) disable iff (reset_i)
      s_exec(SEL_INC) |=>
      $stable(carry_flag_o) && $stable(digit_carry_flag_o) && done_o)
      else $error("increment disturbed carry flags");

   chk_idle_hold: assert property (@(posedge clock_i) disable iff (reset_i)
      !exec_i |=>
      $stable(acc_o) && $stable(zero_flag_o) && !done_o)
      else $error("state changed while idle");

   chk_idle_flags: assert property (@(posedge clock_i) disable iff (reset_i)
      !exec_i |=>
      $stable(carry_flag_o) && $stable(digit_carry_flag_o))
      else $error("carry flags changed while idle");

   // Decoding of the selector and address fields
   chk_none_hold: assert property (@(posedge clock_i) disable iff (reset_i)
      exec_i && op == MTA_NONE |=>
      $stable(acc_o) && $stable(zero_flag_o) && !done_o)
      else $error("unknown selector changed state");

   chk_addr_field: assert property (@(posedge clock_i) disable iff (reset_i)
      operand_addr_o == opcode_i[4:0])
      else $error("operand address wrong");

   // Reset clears the accumulator and every flag
   chk_reset_clear: assert property (@(posedge clock_i)
      reset_i |=>
      acc_o == 8'h00 && !zero_flag_o && !carry_flag_o && !digit_carry_flag_o && !done_o)
      else $error("reset left state behind");
endmodule

/* inc/mtaalu_pkg.sv */
package mtaalu_pkg;
   // Opcode field layout
   localparam int OPC_W      = 12;
   localparam int ADDR_W     = 5;
   localparam int SEL_LSB    = 5;
   localparam int SEL_W      = 7;
   // Instruction selector values (opcode bits 11:5)
   localparam logic [6:0] SEL_COPY = 7'h10;
   localparam logic [6:0] SEL_COMP = 7'h12;
   localparam logic [6:0] SEL_SUB  = 7'h04;
   localparam logic [6:0] SEL_DEC  = 7'h06;
   localparam logic [6:0] SEL_INC  = 7'h14;
   // Reset values and datapath constants
   localparam logic [7:0] ACC_RST   = 8'h00;
   localparam logic       FLAG_RST  = 1'b0;
   localparam logic [7:0] ALL_ONES  = 8'hff;
   localparam logic [7:0] ONE       = 8'h01;
   localparam logic [7:0] ZERO      = 8'h00;
   // Operation selector
   typedef enum logic [2:0] {
      MTA_NONE,
      MTA_COPY,
      MTA_COMP,
      MTA_SUB,
      MTA_DEC,
      MTA_INC
   } mtaalu_op_type;
endpackage

/* design/mtaalu_decode.sv */
// Turns a 12-bit opcode into one of the five loads, or none for other selectors, and an operand address
module mtaalu_decode
   import mtaalu_pkg::*;
(
   input  wire logic [11:0]            opcode_i, // Fetched opcode
   output mtaalu_pkg::mtaalu_op_type   op_o,     // Decoded operation
   output logic [4:0]                  addr_o    // File register operand address
);
   // High bits select instruction, low five address the operand
   always_comb begin
      addr_o = opcode_i[ADDR_W-1:0];
      if (opcode_i[OPC_W-1:SEL_LSB] == SEL_COPY) begin
         op_o = MTA_COPY;
      end else if (opcode_i[OPC_W-1:SEL_LSB] == SEL_COMP) begin
         op_o = MTA_COMP;
      end else if (opcode_i[OPC_W-1:SEL_LSB] == SEL_SUB) begin
         op_o = MTA_SUB;
      end else if (opcode_i[OPC_W-1:SEL_LSB] == SEL_DEC) begin
         op_o = MTA_DEC;
      end else if (opcode_i[OPC_W-1:SEL_LSB] == SEL_INC) begin
         op_o = MTA_INC;
      end else begin
         op_o = MTA_NONE;
      end
   end
endmodule

/* tb/mtaalu_regfile_model.sv */
// File register array seen by the load block
module mtaalu_regfile_model (
   input  wire logic       clock_i,     // Core clock
   input  wire logic [4:0] addr_i,      // Operand address from the block
   input  wire logic       write_i,     // Write-back strobe from the block
   input  wire logic       load_i,      // Bench preload strobe
   input  wire logic [4:0] load_addr_i, // Preload address
   input  wire logic [7:0] load_data_i, // Preload data
   output logic [7:0]      rdata_o      // Operand read data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [32];
   ////////////////////////////////////////////////////////////////
   // Preload, and a visible corruption on any stray write-back outside a preload cycle
   always @(posedge clock_i) begin
      if (load_i) mem[load_addr_i] <= load_data_i;
      else if (write_i) mem[addr_i] <= ~mem[addr_i];
   end
   // Same-cycle read of the addressed operand
   assign rdata_o = mem[addr_i];
endmodule

/* tb/move_to_accumulator_alu_bench.sv */
// Random and directed load sequences against a reference model
module move_to_accumulator_alu_bench;
   import mtaalu_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0, reset_i = 1'b1, exec_i = 1'b0, fuse = 1'b1, load_i = 1'b0;
   logic [11:0] opcode_i = 12'h000;
   logic [4:0]  load_addr = 5'h00, op_addr;
   logic [7:0]  load_data = 8'h00, rdata, acc, e_acc, shadow [32];
   logic        op_wr, zf, carry_seen, dcf, done, e_z, e_c, e_d, e_done;
   int          err_total, num_checks;
   localparam logic [6:0] SELS [6] = '{SEL_COPY, SEL_COMP, SEL_SUB, SEL_DEC, SEL_INC, 7'h3f};
   localparam logic [7:0] PRE [4] = '{8'h00, 8'hff, 8'h01, 8'h0f};
   localparam int DSEL [7] = '{0, 1, 3, 4, 2, 0, 2};
   localparam int DADR [7] = '{0, 1, 2, 1, 3, 1, 0};
   ////////////////////////////////////////////////////////////////
   // Clock, design and partner
   always #20 clock_i = ~clock_i;
   mtaalu_core dut_u (.clock_i(clock_i), .reset_i(reset_i), .exec_i(exec_i),
      .opcode_i(opcode_i), .file_register_operand_i(rdata), .carry_in_fuse_bit_i(fuse),
      .operand_addr_o(op_addr), .operand_write_o(op_wr), .acc_o(acc), .zero_flag_o(zf),
      .carry_flag_o(carry_seen), .digit_carry_flag_o(dcf), .done_o(done));
   mtaalu_regfile_model part_u (.clock_i(clock_i), .addr_i(op_addr), .write_i(op_wr),
      .load_i(load_i), .load_addr_i(load_addr), .load_data_i(load_data), .rdata_o(rdata));
   ////////////////////////////////////////////////////////////////
   // Compare and verdict
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Drive one op, check the previous one, then predict this one
   task automatic step(input logic ex, input logic [6:0] sel, input logic [4:0] a,
                       input logic fz, input logic rst);
      logic [7:0] d;
      logic [8:0] r;
      logic [4:0] lo;
      logic       b;
      @(posedge clock_i);
      exec_i <= ex;
      opcode_i <= {sel, a};
      fuse <= fz;
      reset_i <= rst;
      @(negedge clock_i);
      check("acc", e_acc, acc);
      check("zero", {7'h00, e_z}, {7'h00, zf});
      check("carry", {7'h00, e_c}, {7'h00, carry_seen});
      check("digit", {7'h00, e_d}, {7'h00, dcf});
      check("done", {7'h00, e_done}, {7'h00, done});
      check("write", 8'h00, {7'h00, op_wr});
      check("addr", {3'h0, a}, {3'h0, op_addr});
      d = shadow[a];
      b = ~fz & ~e_c;
      e_done = ex;
      r = 9'h000;
      if (ex) case (sel)
         SEL_COPY: r = {1'b0, d};
         SEL_COMP: r = {1'b0, d ^ ALL_ONES};
         SEL_SUB: begin
            r = {1'b0, d} - {1'b0, e_acc} - {8'h00, b};
            lo = {1'b0, d[3:0]} - {1'b0, e_acc[3:0]} - {4'h0, b};
            e_c = ~r[8];
            e_d = ~lo[4];
         end
         SEL_DEC: r = {1'b0, d - ONE};
         SEL_INC: r = {1'b0, d + ONE};
         default: e_done = 1'b0;
      endcase
      if (e_done) begin
         e_acc = r[7:0];
         e_z = (r[7:0] == ZERO);
      end
      if (rst) {e_acc, e_z, e_c, e_d, e_done} = {ACC_RST, 4'h0};
   endtask
   ////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #40000;
      err_total++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      {e_acc, e_z, e_c, e_d, e_done} = {ACC_RST, 4'h0};
      void'($urandom(27));
      repeat (8) @(posedge clock_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         @(posedge clock_i);
         shadow[i] = (i < 4) ? PRE[i] : 8'($urandom);
         load_i <= 1'b1;
         load_addr <= 5'(i);
         load_data <= shadow[i];
      end
      @(posedge clock_i);
      load_i <= 1'b0;
      for (int i = 0; i < 7; i++) step(1'b1, SELS[DSEL[i]], 5'(DADR[i]), i != 6, 1'b0);
      for (int i = 0; i < 300; i++)
         step($urandom % 4 != 0, SELS[$urandom % 6], 5'($urandom), 1'($urandom), i == 150);
      step(1'b0, SEL_COPY, 5'h00, 1'b1, 1'b0);
      report_and_stop();
   end
endmodule
